// ---- pkg/bst_consts.vh ----
// Constants for the boundary-scan test access port
`ifndef BST_CONSTS_VH
`define BST_CONSTS_VH

`define BST_IR_W        4
`define BST_IR_EXTEST   4'h0
`define BST_IR_SAMPLE   4'h1
`define BST_IR_IDCODE   4'h2
`define BST_IR_BYPASS   4'hF
`define BST_IR_CAPTURE  4'h1
`define BST_BYP_CAPTURE 1'b0

`define BST_ID_W        32
// Arbitrary identification value; least significant bit must be 1
`define BST_ID_VALUE    32'h05A0_0001

`define BST_FULL_BIDIR  125
`define BST_FULL_OUT    33
`define BST_FULL_IN     14
`define BST_FULL_LEN    330
`define BST_RED_BIDIR   116
`define BST_RED_OUT     30
`define BST_RED_IN      11
`define BST_RED_LEN     303

// Pin synchroniser reset, order {trst_n, tdi, tms, tck}
`define BST_SYNC_RST    4'h6
`define BST_PIN_TCK     0
`define BST_PIN_TMS     1
`define BST_PIN_TDI     2
`define BST_PIN_TRST_N  3

`endif

// ---- core/bst_cell.v ----
// One boundary-scan cell: capture/shift stage plus falling-edge update latch
`timescale 1ns/10ps
module bst_cell (
  input  wire clock,
  input  wire rst_n,
  input  wire cap_val,
  input  wire ser_in,
  input  wire capture,
  input  wire shift,
  input  wire update,
  output wire ser_out,
  output wire upd_val
);
  reg shift_q;
  reg upd_q;

  always @(posedge clock) begin
    if (!rst_n) begin
      shift_q <= 1'b0;
      upd_q   <= 1'b0;
    end else begin
      if (capture) begin
        shift_q <= cap_val;
      end else if (shift) begin
        shift_q <= ser_in;
      end
      // Update strobe only comes on a falling scan clock edge
      if (update) begin
        upd_q <= shift_q;
      end
    end
  end

  assign ser_out = shift_q;
  assign upd_val = upd_q;
endmodule

// ---- core/bst_tap.v ----
// System-logic test access port with boundary-scan chain
//
// Functional notes
// (R1) Tester keeps at least one of the two ports in reset; tdo shared.
// (R2) Tester resets the unused port with its mode-select high five clocks.
// (R3) Scan reset or mode-select high five clocks resets this port.
// (R4) Sixteen-state controller, four-bit instruction register, five scan pins.
// (R5) State moves on mode-select sampled at each rising scan clock edge.
// (R6) Reset state entered by scan reset or five clocks of mode-select high.
// (R7) Bypass, boundary and identification registers share serial in and out.
// (R8) Full chain is 330 bits, 172 elements; scan pins have no cells.
// (R9) Full chain: 125 bidirectional, 33 output, 14 input cells.
// (R10) Reduced chain: 303 bits, 116 bidirectional, 30 output, 11 input.
// (R11) Boundary chain in path only for external-test or sample/preload.
// (R12) External-test drives update latches onto pins once it becomes current.
// (R13) Tester preloads safe values before selecting external-test.
// (R14) Every cell updates its latch on the falling scan clock edge.
// (R15) Input cells only observe the pin; they never drive anything.
// (R16) Bidirectional capture takes core output when enabled and not testing.
// (R17) Bidirectional capture takes pad value when its enable is low.
// (R18) Instruction shifted on rising edges, made current at Update-IR.
// (R19) Four instruction cells, least significant bit nearest serial out.
// (R20) Instruction selects the data path; others leave the chip alone.
// (R21) Bypass bit loads zero in Capture-DR.
// (R22) Reset makes identification current; first shifted bit is one.
// (R23) Capture-IR loads a fixed value with lowest bits 01.
// (R24) Unassigned instruction codes behave as bypass.
// (R25) Serial out driven only in shift states, changes on falling edge.
// (R26) Scan reset forces reset state without waiting for a scan clock.
`timescale 1ns/10ps
`include "bst_consts.vh"
module bst_tap #(
  parameter        NB       = `BST_FULL_BIDIR,
  parameter        NO       = `BST_FULL_OUT,
  parameter        NI       = `BST_FULL_IN,
  parameter [31:0] ID_VALUE = `BST_ID_VALUE
) (
  input  wire          clock,
  input  wire          rst_n,
  input  wire          tck,
  input  wire          tms,
  input  wire          tdi,
  input  wire          trst_n,
  output wire          tdo,
  output wire          tdo_oe,
  input  wire [NB-1:0] core_bd_data,
  input  wire [NB-1:0] core_bd_en,
  input  wire [NB-1:0] pad_bd_in,
  output wire [NB-1:0] pad_bd_data,
  output wire [NB-1:0] pad_bd_en,
  input  wire [NO-1:0] core_out_data,
  input  wire [NO-1:0] core_out_en,
  output wire [NO-1:0] pad_out_data,
  output wire [NO-1:0] pad_out_en,
  input  wire [NI-1:0] pad_in_val
);
  localparam L    = 2 * NB + 2 * NO + NI; // R8 R9 R10
  localparam OB   = 2 * NB;
  localparam IB   = 2 * NB + 2 * NO;

  localparam [3:0] S_TLR    = 4'h0;
  localparam [3:0] S_RTI    = 4'h1;
  localparam [3:0] S_SEL_DR = 4'h2;
  localparam [3:0] S_CAP_DR = 4'h3;
  localparam [3:0] S_SH_DR  = 4'h4;
  localparam [3:0] S_EX1_DR = 4'h5;
  localparam [3:0] S_PA_DR  = 4'h6;
  localparam [3:0] S_EX2_DR = 4'h7;
  localparam [3:0] S_UPD_DR = 4'h8;
  localparam [3:0] S_SEL_IR = 4'h9;
  localparam [3:0] S_CAP_IR = 4'hA;
  localparam [3:0] S_SH_IR  = 4'hB;
  localparam [3:0] S_EX1_IR = 4'hC;
  localparam [3:0] S_PA_IR  = 4'hD;
  localparam [3:0] S_EX2_IR = 4'hE;
  localparam [3:0] S_UPD_IR = 4'hF;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: three stages, a change counts when stages 2 and 3 agree
  wire [3:0] pin_raw;
  reg  [3:0] sync1_q;
  reg  [3:0] sync2_q;
  reg  [3:0] sync3_q;
  reg  [3:0] pin_q;
  reg        tck_prev_q;

  localparam [3:0] SYNC_RST = `BST_SYNC_RST;

  assign pin_raw = {trst_n, tdi, tms, tck};

  genvar gp;
  generate
    for (gp = 0; gp < 4; gp = gp + 1) begin : g_sync
      always @(posedge clock) begin
        if (!rst_n) begin
          sync1_q[gp] <= SYNC_RST[gp];
          sync2_q[gp] <= SYNC_RST[gp];
          sync3_q[gp] <= SYNC_RST[gp];
          pin_q[gp]   <= SYNC_RST[gp];
        end else begin
          sync1_q[gp] <= pin_raw[gp];
          sync2_q[gp] <= sync1_q[gp];
          sync3_q[gp] <= sync2_q[gp];
          if (sync2_q[gp] == sync3_q[gp]) begin
            pin_q[gp] <= sync3_q[gp];
          end
        end
      end
    end
  endgenerate

  always @(posedge clock) begin
    if (!rst_n) begin
      tck_prev_q <= 1'b0;
    end else begin
      tck_prev_q <= pin_q[`BST_PIN_TCK];
    end
  end

  wire tck_rise  = pin_q[`BST_PIN_TCK] & ~tck_prev_q;
  wire tck_fall  = ~pin_q[`BST_PIN_TCK] & tck_prev_q;
  wire tms_s     = pin_q[`BST_PIN_TMS];
  wire tdi_s     = pin_q[`BST_PIN_TDI];
  wire trst_n_s  = pin_q[`BST_PIN_TRST_N];

  ////////////////////////////////////////////////////////////////////////////
  // Controller state machine
  reg [3:0] st_q;
  reg [3:0] st_d;

  always @* begin
    case (st_q)
      S_TLR:    st_d = tms_s ? S_TLR    : S_RTI; // R6
      S_RTI:    st_d = tms_s ? S_SEL_DR : S_RTI;
      S_SEL_DR: st_d = tms_s ? S_SEL_IR : S_CAP_DR;
      S_CAP_DR: st_d = tms_s ? S_EX1_DR : S_SH_DR;
      S_SH_DR:  st_d = tms_s ? S_EX1_DR : S_SH_DR;
      S_EX1_DR: st_d = tms_s ? S_UPD_DR : S_PA_DR;
      S_PA_DR:  st_d = tms_s ? S_EX2_DR : S_PA_DR;
      S_EX2_DR: st_d = tms_s ? S_UPD_DR : S_SH_DR;
      S_UPD_DR: st_d = tms_s ? S_SEL_DR : S_RTI;
      S_SEL_IR: st_d = tms_s ? S_TLR    : S_CAP_IR;
      S_CAP_IR: st_d = tms_s ? S_EX1_IR : S_SH_IR;
      S_SH_IR:  st_d = tms_s ? S_EX1_IR : S_SH_IR;
      S_EX1_IR: st_d = tms_s ? S_UPD_IR : S_PA_IR;
      S_PA_IR:  st_d = tms_s ? S_EX2_IR : S_PA_IR;
      S_EX2_IR: st_d = tms_s ? S_UPD_IR : S_SH_IR;
      S_UPD_IR: st_d = tms_s ? S_SEL_DR : S_RTI;
      default:  st_d = S_TLR;
    endcase
  end

  always @(posedge clock) begin
    if (!rst_n) begin
      st_q <= S_TLR;
    end else if (!trst_n_s) begin
      st_q <= S_TLR; // R3 R6 R26
    end else if (tck_rise) begin
      st_q <= st_d; // R4 R5
    end
  end

  wire in_tlr  = (st_q == S_TLR);
  wire cap_dr  = tck_rise & (st_q == S_CAP_DR);
  wire sh_dr   = tck_rise & (st_q == S_SH_DR);
  wire upd_dr  = tck_fall & (st_q == S_UPD_DR);

  ////////////////////////////////////////////////////////////////////////////
  // Instruction register
  reg [`BST_IR_W-1:0] ir_sh_q;
  reg [`BST_IR_W-1:0] ir_q;

  always @(posedge clock) begin
    if (!rst_n) begin
      ir_sh_q <= `BST_IR_CAPTURE;
      ir_q    <= `BST_IR_IDCODE;
    end else begin
      if (tck_rise && st_q == S_CAP_IR) begin
        ir_sh_q <= `BST_IR_CAPTURE; // R23
      end else if (tck_rise && st_q == S_SH_IR) begin
        ir_sh_q <= {tdi_s, ir_sh_q[`BST_IR_W-1:1]}; // R18 R19
      end
      if (in_tlr) begin
        ir_q <= `BST_IR_IDCODE; // R22
      end else if (tck_fall && st_q == S_UPD_IR) begin
        ir_q <= ir_sh_q; // R18
      end
    end
  end

  wire sel_ext = (ir_q == `BST_IR_EXTEST);
  wire sel_bsr = sel_ext | (ir_q == `BST_IR_SAMPLE); // R11
  wire sel_id  = (ir_q == `BST_IR_IDCODE);
  // Anything else, assigned or not, takes the bypass bit
  wire sel_byp = ~sel_bsr & ~sel_id; // R24

  ////////////////////////////////////////////////////////////////////////////
  // Bypass and identification registers
  reg                 byp_q;
  reg [`BST_ID_W-1:0] id_q;

  always @(posedge clock) begin
    if (!rst_n) begin
      byp_q <= `BST_BYP_CAPTURE;
      id_q  <= ID_VALUE;
    end else begin
      if (cap_dr && sel_byp) begin
        byp_q <= `BST_BYP_CAPTURE; // R21
      end else if (sh_dr && sel_byp) begin
        byp_q <= tdi_s;
      end
      if (cap_dr && sel_id) begin
        id_q <= ID_VALUE; // R22
      end else if (sh_dr && sel_id) begin
        id_q <= {tdi_s, id_q[`BST_ID_W-1:1]};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Boundary chain; bit 0 is nearest the serial output
  wire [L-1:0] cap_vec;
  wire [L-1:0] ser_vec;
  wire [L-1:0] upd_vec;
  wire [NB-1:0] upd_bd_data;
  wire [NB-1:0] upd_bd_en;
  wire [NO-1:0] upd_out_data;
  wire [NO-1:0] upd_out_en;

  genvar gb;
  generate
    for (gb = 0; gb < NB; gb = gb + 1) begin : g_bidir
      wire en_eff = sel_ext ? upd_vec[2*gb+1] : core_bd_en[gb];
      // R16 R17
      assign cap_vec[2*gb]   = (en_eff & ~sel_ext) ? core_bd_data[gb] : pad_bd_in[gb];
      assign cap_vec[2*gb+1] = core_bd_en[gb];
      assign upd_bd_data[gb] = upd_vec[2*gb];
      assign upd_bd_en[gb]   = upd_vec[2*gb+1];
    end
    for (gb = 0; gb < NO; gb = gb + 1) begin : g_out
      assign cap_vec[OB+2*gb]   = core_out_data[gb];
      assign cap_vec[OB+2*gb+1] = core_out_en[gb];
      assign upd_out_data[gb]   = upd_vec[OB+2*gb];
      assign upd_out_en[gb]     = upd_vec[OB+2*gb+1];
    end
    for (gb = 0; gb < NI; gb = gb + 1) begin : g_in
      assign cap_vec[IB+gb] = pad_in_val[gb]; // R15
    end
    for (gb = 0; gb < L; gb = gb + 1) begin : g_cell
      wire sin = (gb == L - 1) ? tdi_s : ser_vec[(gb + 1) % L];
      bst_cell u_cell (
        .clock   (clock),
        .rst_n   (rst_n),
        .cap_val (cap_vec[gb]),
        .ser_in  (sin),
        .capture (cap_dr & sel_bsr),  // R7 R20
        .shift   (sh_dr & sel_bsr),   // R11
        .update  (upd_dr & sel_bsr),  // R14
        .ser_out (ser_vec[gb]),
        .upd_val (upd_vec[gb])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers: latched test values while external-test is current
  reg [NB-1:0] pad_bd_data_q;
  reg [NB-1:0] pad_bd_en_q;
  reg [NO-1:0] pad_out_data_q;
  reg [NO-1:0] pad_out_en_q;

  always @(posedge clock) begin
    if (!rst_n) begin
      pad_bd_data_q  <= {NB{1'b0}};
      pad_bd_en_q    <= {NB{1'b0}};
      pad_out_data_q <= {NO{1'b0}};
      pad_out_en_q   <= {NO{1'b0}};
    end else if (sel_ext) begin
      pad_bd_data_q  <= upd_bd_data; // R12
      pad_bd_en_q    <= upd_bd_en;
      pad_out_data_q <= upd_out_data;
      pad_out_en_q   <= upd_out_en;
    end else begin
      pad_bd_data_q  <= core_bd_data; // R20
      pad_bd_en_q    <= core_bd_en;
      pad_out_data_q <= core_out_data;
      pad_out_en_q   <= core_out_en;
    end
  end

  assign pad_bd_data  = pad_bd_data_q;
  assign pad_bd_en    = pad_bd_en_q;
  assign pad_out_data = pad_out_data_q;
  assign pad_out_en   = pad_out_en_q;

  ////////////////////////////////////////////////////////////////////////////
  // Serial output, updated on the falling scan clock edge
  reg tdo_q;
  reg tdo_oe_q;
  reg tdo_d;

  always @* begin
    if (st_q == S_SH_IR) begin
      tdo_d = ir_sh_q[0]; // R19
    end else if (sel_bsr) begin
      tdo_d = ser_vec[0];
    end else if (sel_id) begin
      tdo_d = id_q[0];
    end else begin
      tdo_d = byp_q;
    end
  end

  always @(posedge clock) begin
    if (!rst_n) begin
      tdo_q    <= 1'b0;
      tdo_oe_q <= 1'b0;
    end else if (in_tlr) begin
      tdo_oe_q <= 1'b0; // R1
    end else if (tck_fall) begin
      tdo_q    <= tdo_d; // R25
      tdo_oe_q <= (st_q == S_SH_IR) | (st_q == S_SH_DR); // R25
    end
  end

  assign tdo    = tdo_q;
  assign tdo_oe = tdo_oe_q;
endmodule

// ---- verif/bst_tap_chk.sv ----
// Assertion checker for the scan test port
`timescale 1ns/10ps
module bst_tap_chk #(
  parameter NB = 125,
  parameter NO = 33
) (
  input wire          clock,
  input wire          rst_n,
  input wire          tck,
  input wire          tms,
  input wire          trst_n,
  input wire          tdo,
  input wire          tdo_oe,
  input wire [NB-1:0] core_bd_data,
  input wire [NB-1:0] core_bd_en,
  input wire [NB-1:0] pad_bd_data,
  input wire [NB-1:0] pad_bd_en,
  input wire [NO-1:0] core_out_data,
  input wire [NO-1:0] core_out_en,
  input wire [NO-1:0] pad_out_data,
  input wire [NO-1:0] pad_out_en
);
  reg       tck_q;
  reg       tms1_q;
  reg [5:0] fall_q;
  reg [5:0] trl_q;
  // Clocks since the last scan clock fall, and since scan reset went low
  always @(posedge clock) begin
    if (!rst_n) begin
      tck_q  <= 1'b0;
      tms1_q <= 1'b0;
      fall_q <= 6'h3F;
      trl_q  <= 6'h00;
    end else begin
      tck_q  <= tck;
      if (tck && !tck_q) tms1_q <= tms;
      fall_q <= (tck_q && !tck) ? 6'h01 : fall_q + {5'h00, fall_q != 6'h3F};
      trl_q  <= trst_n ? 6'h00 : trl_q + {5'h00, trl_q != 6'h3F};
    end
  end
  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_reset_quiet: assert property ($rose(rst_n) |-> !tdo_oe && !tdo)
    else $error("scan output active after reset");
  a_trst_idle: assert property (trl_q > 6'h06 |-> !tdo_oe)
    else $error("scan output active under scan reset");
  a_oe_after_fall: assert property ($rose(tdo_oe) |-> fall_q <= 6'h06)
    else $error("output enable rose away from a falling scan clock");
  a_tdo_after_fall: assert property (tdo_oe && $past(tdo_oe) && $changed(tdo)
    |-> fall_q <= 6'h06)
    else $error("serial output changed away from a falling scan clock");
  a_exit_shift: assert property (tms1_q && fall_q == 6'h06 |-> !tdo_oe)
    else $error("output still driven after leaving shift");
  a_bd_follow: assert property (trl_q > 6'h06 |-> pad_bd_data == $past(core_bd_data))
    else $error("bidirectional pad data does not follow core");
  a_bden_follow: assert property (trl_q > 6'h06 |-> pad_bd_en == $past(core_bd_en))
    else $error("bidirectional pad enable does not follow core");
  a_out_follow: assert property (trl_q > 6'h06 |-> pad_out_data == $past(core_out_data))
    else $error("output pad data does not follow core");
  a_outen_follow: assert property (trl_q > 6'h06 |-> pad_out_en == $past(core_out_en))
    else $error("output pad enable does not follow core");
  c_shift: cover property ($rose(tdo_oe));
  c_trst: cover property (trl_q > 6'h06);
  c_exit: cover property (tms1_q && fall_q == 6'h06);
endmodule

// ---- verif/bst_tester.sv ----
// Board tester model driving the scan pins
`timescale 1ns/10ps
module bst_tester (
  output logic tck,
  output logic tms,
  output logic tdi,
  input  wire  tdo,
  input  wire  tdo_oe
);
  logic last;
  // Scan clock stands low between transfers; mode select idles high
  initial begin
    tck  = 1'b0;
    tms  = 1'b1;
    tdi  = 1'b1;
    last = 1'b0;
  end
  // A released serial line shows the inverse of its last value
  task automatic cyc(input logic m, input logic d, output logic q);
    tms <= m;
    tdi <= d;
    #62.5;
    q = tdo_oe ? tdo : ~last;
    last = q;
    tck = 1'b1;
    #62.5;
    tck = 1'b0;
  endtask
  // From run-test-idle through one scan and back to idle
  task automatic scan(input logic ir, input int n, input logic [511:0] din,
                      output logic [511:0] dout);
    logic q;
    dout = '0;
    cyc(1'b1, 1'b0, q);
    if (ir) cyc(1'b1, 1'b0, q);
    cyc(1'b0, 1'b0, q);
    cyc(1'b0, 1'b0, q);
    for (int i = 0; i < n; i++) begin
      cyc(i == n - 1, din[i], q);
      dout[i] = q;
    end
    cyc(1'b1, 1'b0, q);
    cyc(1'b0, 1'b0, q);
  endtask
endmodule

// ---- verif/boundary_scan_tap_controller_tb.sv ----
// Testbench for the scan test port
`timescale 1ns/10ps
`include "bst_consts.vh"
module boundary_scan_tap_controller_tb;
  localparam NB = 125;
  localparam NO = 33;
  localparam NI = 14;
  logic          clock = 1'b0;
  logic          rst_n = 1'b0;
  logic          trst_n = 1'b0;
  logic [NB-1:0] core_bd_data, core_bd_en, pad_bd_in;
  logic [NO-1:0] core_out_data, core_out_en;
  logic [NI-1:0] pad_in_val;
  wire           tck, tms, tdi, tdo, tdo_oe;
  wire  [NB-1:0] pad_bd_data, pad_bd_en;
  wire  [NO-1:0] pad_out_data, pad_out_en;
  int            n_mismatch = 0;
  int            checks = 0;
  logic [511:0]  dout;
  logic          q;
  typedef struct packed {
    logic [3:0]  ir;
    logic [8:0]  len;
    logic [31:0] din;
    logic [31:0] exp;
  } bst_row_t;
  bst_row_t rows [5] = '{
    '{4'hF, 9'h009, 32'h0B5, 32'h16A},
    '{4'h7, 9'h009, 32'h0B5, 32'h16A},
    '{4'hA, 9'h009, 32'h0B5, 32'h16A},
    '{`BST_IR_IDCODE, 9'h020, 32'h0, `BST_ID_VALUE},
    '{`BST_IR_SAMPLE, 9'h008, 32'h0, 32'h33}};
  always #5 clock = ~clock;
  bst_tap u_dut (.clock, .rst_n, .tck, .tms, .tdi, .trst_n, .tdo, .tdo_oe,
    .core_bd_data, .core_bd_en, .pad_bd_in, .pad_bd_data, .pad_bd_en,
    .core_out_data, .core_out_en, .pad_out_data, .pad_out_en, .pad_in_val);
  bst_tester u_tst (.tck, .tms, .tdi, .tdo, .tdo_oe);
  ////////////////////////////////////////////////////////////////
  task automatic cmp(input logic [511:0] got, input logic [511:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic ld_ir(input logic [3:0] code);
    u_tst.scan(1'b1, 4, code, dout);
    cmp(dout, 512'h1);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    core_bd_data  = '1;
    core_bd_en    = NB'(4'h5);
    pad_bd_in     = '0;
    core_out_data = '0;
    core_out_en   = '0;
    pad_in_val    = 14'h2A5C;
    repeat (4) @(posedge clock);
    rst_n  <= 1'b1;
    trst_n <= 1'b1;
    repeat (6) @(posedge clock);
    cmp(tdo_oe, 1'b0);
    u_tst.cyc(1'b0, 1'b0, q);
    ld_ir(`BST_IR_BYPASS);
    repeat (5) u_tst.cyc(1'b1, 1'b0, q);
    u_tst.cyc(1'b0, 1'b0, q);
    u_tst.scan(1'b0, 32, 512'h0, dout);
    cmp(dout, `BST_ID_VALUE);
    foreach (rows[i]) begin
      ld_ir(rows[i].ir);
      u_tst.scan(1'b0, rows[i].len, rows[i].din, dout);
      cmp(dout, rows[i].exp);
    end
    ld_ir(`BST_IR_BYPASS);
    u_tst.cyc(1'b1, 1'b0, q);
    repeat (3) u_tst.cyc(1'b0, 1'b0, q);
    cmp(tdo_oe, 1'b1);
    @(posedge clock);
    trst_n <= 1'b0;
    repeat (8) @(posedge clock);
    cmp(tdo_oe, 1'b0);
    core_bd_data  <= '0;
    core_out_data <= '1;
    core_out_en   <= '1;
    repeat (8) @(posedge clock);
    trst_n <= 1'b1;
    repeat (6) @(posedge clock);
    u_tst.cyc(1'b0, 1'b0, q);
    u_tst.scan(1'b0, 32, 512'h0, dout);
    cmp(dout, `BST_ID_VALUE);
    ld_ir(`BST_IR_SAMPLE);
    u_tst.scan(1'b0, 338, {{250{1'b1}}, 8'hA5}, dout);
    cmp(dout[337:330], 8'hA5);
    cmp(dout[329:316], 14'h2A5C);
    cmp(dout[315:250], {66{1'b1}});
    cmp(dout[249:0], 512'h22);
    ld_ir(`BST_IR_EXTEST);
    repeat (4) @(posedge clock);
    cmp(pad_bd_data, {NB{1'b1}});
    cmp(pad_bd_en, {NB{1'b1}});
    cmp(pad_out_data, 512'h0);
    cmp(pad_out_en, 512'h0);
    u_tst.scan(1'b0, 330, 512'h0, dout);
    cmp(dout[3:0], 4'h2);
    repeat (4) @(posedge clock);
    cmp(pad_bd_data, 512'h0);
    stop_test();
  end
  initial begin
    #600us;
    n_mismatch++;
    stop_test();
  end
endmodule
bind bst_tap bst_tap_chk #(.NB(NB), .NO(NO)) u_chk (.clock, .rst_n, .tck, .tms, .trst_n,
  .tdo, .tdo_oe, .core_bd_data, .core_bd_en, .pad_bd_data, .pad_bd_en,
  .core_out_data, .core_out_en, .pad_out_data, .pad_out_en);
